// ---- rtl/hltm_pkg.sv ----
// Package with constants and carrier types for the hardware limit timer.
package hltm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int HLTM_DW = 8;
  localparam int HLTM_AW = 2;
  localparam int HLTM_MW = 5;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] HLTM_OFS_COUNT = 2'h0;
  localparam logic [1:0] HLTM_OFS_PERIOD = 2'h1;
  localparam logic [1:0] HLTM_OFS_CTRL = 2'h2;
  localparam logic [1:0] HLTM_OFS_MODE = 2'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int HLTM_RUN_BIT = 7;
  localparam logic [7:0] HLTM_COUNT_RST = 8'h00;
  localparam logic [7:0] HLTM_PERIOD_RST = 8'hff;
  localparam logic [4:0] HLTM_MODE_RST = 5'h00;

  // ----------------------------------------------------------------
  // Timing: stages between a control input and its effect
  // ----------------------------------------------------------------
  localparam int HLTM_SYNC_CLKS = 2;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [4:0] HLTM_M_SWGATE = 5'h00;
  localparam logic [4:0] HLTM_M_GATE_HI = 5'h01;
  localparam logic [4:0] HLTM_M_GATE_LO = 5'h02;
  localparam logic [4:0] HLTM_M_ELIM_ANY = 5'h03;
  localparam logic [4:0] HLTM_M_ELIM_RISE = 5'h04;
  localparam logic [4:0] HLTM_M_ELIM_FALL = 5'h05;
  localparam logic [4:0] HLTM_M_LLIM_LO = 5'h06;
  localparam logic [4:0] HLTM_M_LLIM_HI = 5'h07;
  localparam logic [4:0] HLTM_M_OS_SW = 5'h08;
  localparam logic [4:0] HLTM_M_OS_RISE = 5'h09;
  localparam logic [4:0] HLTM_M_OS_FALL = 5'h0a;
  localparam logic [4:0] HLTM_M_OS_ANY = 5'h0b;
  localparam logic [4:0] HLTM_M_OSE_RISE = 5'h0c;
  localparam logic [4:0] HLTM_M_OSE_FALL = 5'h0d;
  localparam logic [4:0] HLTM_M_OSL_LO = 5'h0e;
  localparam logic [4:0] HLTM_M_OSL_HI = 5'h0f;
  localparam logic [4:0] HLTM_M_MONO_RISE = 5'h11;
  localparam logic [4:0] HLTM_M_MONO_FALL = 5'h12;
  localparam logic [4:0] HLTM_M_MONO_ANY = 5'h13;
  localparam logic [4:0] HLTM_M_OSH_LO = 5'h16;
  localparam logic [4:0] HLTM_M_OSH_HI = 5'h17;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [HLTM_AW-1:0] addr;
    logic [HLTM_DW-1:0] wdata;
    logic wr;
    logic rd;
  } hltm_req_type;

endpackage

// ---- rtl/hltm_timer.sv ----
// Eight-bit period timer with hardware limit, one-shot and monostable modes.
// ------------------------------------------------------------------
// Overview of operation
// - Software gate: count up each clock while run set, hold while clear.
// - On count equal to period, clear next clock and keep counting from zero.
// - Hardware gate: 00001 stops while signal high, 00010 stops while low.
// - Edge limit: 00011 any edge, 00100 rising, 00101 falling resets count.
// - Level limit: reset while signal low for 00110, high for 00111.
// - Level limit modes 00110 and 00111 ignore the external signal while run is clear.
// - Level reset acts two clocks after the level; restart two after release.
// - Software one-shot 01000: period match resets count and clears run.
// - Software one-shot: clearing run pauses; setting run resumes two clocks later.
// - Edge one-shot: edge after run set starts; match clears run.
// - Edge one-shot: after run cleared, a fresh edge is needed to resume.
// - Edge limit one-shot: first edge starts, later edges reset count.
// - Edge limit one-shot: edges ignored until run set; match clears run.
// - Level-reset edge one-shot: hold reset at level; start on active edge.
// - Level-reset edge one-shot: match clears run; new edge needed after.
// - Monostable: edge after run set starts; counting stops at match.
// - Level limit one-shot: held at reset level; count when run and inactive.
// - Level limit one-shot: match clears run; stay reset until both conditions.
// - Run bit and external signal pass two clocks of delay before acting.
// - Monostable: after match the count stops at zero, run stays set.
// ------------------------------------------------------------------
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps

module hltm_timer
  import hltm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire hltm_req_type bus_req,
  output logic [HLTM_DW-1:0] bus_rdata,
  // External reset/trigger pin.
  input wire logic ext_reset_signal,
  // Time base towards the capture_compare_unit.
  output logic [HLTM_DW-1:0] count_value,
  output logic [HLTM_DW-1:0] period_value,
  output logic period_match,
  output logic run_state
);

  // ----------------------------------------------------------------
  // Local decode helpers
  // ----------------------------------------------------------------

  // Selects an edge event from the two low mode bits: 1 rise, 2 fall, 3 any.
  function automatic logic sel_edge(
    input logic [1:0] sel,
    input logic rise,
    input logic fall
  );
    logic res;
    res = 1'b0;
    unique case (sel)
      2'h1: res = rise;
      2'h2: res = fall;
      2'h3: res = rise | fall;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // True when the signal sits at the reset level; hi_lvl picks high.
  function automatic logic at_level(
    input logic hi_lvl,
    input logic sig
  );
    return hi_lvl ? sig : ~sig;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic run_r;
  logic [HLTM_MW-1:0] mode_r;
  logic [HLTM_DW-1:0] count_r;
  logic [HLTM_DW-1:0] count_nxt;
  logic [HLTM_DW-1:0] period_r;
  logic [HLTM_DW-1:0] rdata_r;
  logic [HLTM_SYNC_CLKS-1:0] ext_pipe_r;
  logic [HLTM_SYNC_CLKS-1:0] run_pipe_r;
  logic ext_prev_r;
  logic armed_r;
  logic armed_nxt;
  logic match_r;
  logic ext_s;
  logic run_s;
  logic rise;
  logic fall;
  logic match;
  logic cnt_en;
  logic cnt_rst;
  logic hw_clr;
  logic sw_wr_ctrl;
  logic sw_set_run;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------

  // The pin passes two flops; only the last stage is read by logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_pipe_r <= '0;
    end else begin
      ext_pipe_r <= {ext_pipe_r[HLTM_SYNC_CLKS-2:0], ext_reset_signal};
    end
  end

  // Delayed copy of the synchronised signal for edge detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_s;
    end
  end

  // The run bit is delayed by the same two clocks so both line up.
  // A hardware clear without a same-cycle software set empties the pipe so no stale run leaks through.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_pipe_r <= '0;
    end else if (hw_clr && !sw_set_run) begin
      run_pipe_r <= '0;
    end else begin
      run_pipe_r <= {run_pipe_r[HLTM_SYNC_CLKS-2:0], run_r};
    end
  end

  // Delayed views and edge events.
  assign ext_s = ext_pipe_r[HLTM_SYNC_CLKS-1];
  assign run_s = run_pipe_r[HLTM_SYNC_CLKS-1];
  assign rise = ext_s & ~ext_prev_r;
  assign fall = ~ext_s & ext_prev_r;
  assign match = (count_r == period_r);

  // ----------------------------------------------------------------
  // Register port writes
  // ----------------------------------------------------------------
  assign sw_wr_ctrl = bus_req.wr && (bus_req.addr == HLTM_OFS_CTRL);
  assign sw_set_run = sw_wr_ctrl && bus_req.wdata[HLTM_RUN_BIT];

  // Run bit: a software set in the same cycle beats a hardware clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else if (sw_wr_ctrl) begin
      run_r <= bus_req.wdata[HLTM_RUN_BIT];
    end else if (hw_clr) begin
      run_r <= 1'b0;
    end
  end

  // Mode field; software keeps it steady while running.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= HLTM_MODE_RST;
    end else if (bus_req.wr && (bus_req.addr == HLTM_OFS_MODE)) begin
      mode_r <= bus_req.wdata[HLTM_MW-1:0];
    end
  end

  // Period value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_r <= HLTM_PERIOD_RST;
    end else if (bus_req.wr && (bus_req.addr == HLTM_OFS_PERIOD)) begin
      period_r <= bus_req.wdata;
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        HLTM_OFS_COUNT: rdata_r <= count_r;
        HLTM_OFS_PERIOD: rdata_r <= period_r;
        HLTM_OFS_CTRL: rdata_r <= {run_r, 7'h00};
        HLTM_OFS_MODE: rdata_r <= {3'h0, mode_r};
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------

  // Works out counting, reset, arming and hardware clear of run.
  always_comb begin
    cnt_en = 1'b0;
    cnt_rst = 1'b0;
    hw_clr = 1'b0;
    armed_nxt = armed_r;
    unique case (mode_r)
      HLTM_M_SWGATE: begin
        cnt_en = run_s;
      end
      HLTM_M_GATE_HI, HLTM_M_GATE_LO: begin
        cnt_en = run_s & ~at_level(~mode_r[1], ext_s);
      end
      HLTM_M_ELIM_ANY, HLTM_M_ELIM_RISE, HLTM_M_ELIM_FALL: begin
        cnt_en = run_s;
        // Code 3 any, 4 rise, 5 fall mapped onto the edge selector.
        cnt_rst = run_s & sel_edge(mode_r[1:0] == 2'h3 ? 2'h3 :
                                   (mode_r[0] ? 2'h2 : 2'h1),
                                   rise, fall);
      end
      HLTM_M_LLIM_LO, HLTM_M_LLIM_HI: begin
        // The delayed level gives the two-clock reset and restart.
        cnt_rst = run_s & at_level(mode_r[0], ext_s);
        cnt_en = run_s;
      end
      HLTM_M_OS_SW: begin
        cnt_en = run_s;
        hw_clr = run_s & match;
      end
      HLTM_M_OS_RISE, HLTM_M_OS_FALL, HLTM_M_OS_ANY: begin
        if (!run_s) begin
          armed_nxt = 1'b0;
        end else if (sel_edge(mode_r[1:0], rise, fall)) begin
          armed_nxt = 1'b1;
        end
        cnt_en = run_s & armed_r;
        hw_clr = cnt_en & match;
      end
      HLTM_M_OSE_RISE, HLTM_M_OSE_FALL: begin
        if (!run_s) begin
          armed_nxt = 1'b0;
        end else if (sel_edge(mode_r[0] ? 2'h2 : 2'h1, rise, fall)) begin
          armed_nxt = 1'b1;
          cnt_rst = armed_r;
        end
        cnt_en = run_s & armed_r;
        hw_clr = cnt_en & match;
      end
      HLTM_M_OSL_LO, HLTM_M_OSL_HI: begin
        cnt_rst = at_level(mode_r[0], ext_s);
        if (!run_s) begin
          armed_nxt = 1'b0;
        end else if (sel_edge(mode_r[0] ? 2'h2 : 2'h1, rise, fall)) begin
          armed_nxt = 1'b1;
        end
        cnt_en = run_s & armed_r & ~cnt_rst;
        hw_clr = cnt_en & match;
      end
      HLTM_M_MONO_RISE, HLTM_M_MONO_FALL, HLTM_M_MONO_ANY: begin
        if (!run_s) begin
          armed_nxt = 1'b0;
        end else if (armed_r && match) begin
          armed_nxt = 1'b0;
        end else if (sel_edge(mode_r[1:0], rise, fall)) begin
          armed_nxt = 1'b1;
        end
        cnt_en = run_s & armed_r;
      end
      HLTM_M_OSH_LO, HLTM_M_OSH_HI: begin
        cnt_rst = at_level(mode_r[0], ext_s);
        cnt_en = run_s & ~cnt_rst;
        hw_clr = cnt_en & match;
      end
      default: begin
        cnt_en = 1'b0;
      end
    endcase
  end

  // Arming state for the edge-started modes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------

  // Software write first, then external reset, then wrap, then increment.
  always_comb begin
    count_nxt = count_r;
    if (bus_req.wr && (bus_req.addr == HLTM_OFS_COUNT)) begin
      count_nxt = bus_req.wdata;
    end else if (cnt_rst) begin
      count_nxt = HLTM_COUNT_RST;
    end else if (cnt_en && match) begin
      count_nxt = HLTM_COUNT_RST;
    end else if (cnt_en) begin
      count_nxt = count_r + 8'h01;
    end
  end

  // Count register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= HLTM_COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // One-cycle pulse in the clock that wraps the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_r <= 1'b0;
    end else begin
      match_r <= cnt_en & match & ~cnt_rst;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_rdata = rdata_r;
  assign count_value = count_r;
  assign period_value = period_r;
  assign period_match = match_r;
  assign run_state = run_r;

endmodule

// ---- dv/hltm_ers_model.sv ----
// Model of the source that drives the external reset and trigger pin.
`timescale 1ns/100ps
module hltm_ers_model (
  // Clock and requested pin level.
  input wire logic clk,
  input wire logic lvl,
  // Pin towards the timer.
  output logic ext_reset_signal = 1'h0
);
  // ----------------------------------------------------------------
  // Pin driver
  // ----------------------------------------------------------------
  // Launches the requested level just after a rising edge, like a clocked source.
  always @(posedge clk) begin
    ext_reset_signal <= lvl;
  end
endmodule

// ---- dv/hltm_timer_asserts.sv ----
// Concurrent checks on the ports of the hardware limit timer.
`timescale 1ns/100ps
module hltm_timer_chk
  import hltm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire hltm_req_type bus_req,
  input wire logic [HLTM_DW-1:0] bus_rdata,
  // Pin and time base.
  input wire logic ext_reset_signal,
  input wire logic [HLTM_DW-1:0] count_value,
  input wire logic [HLTM_DW-1:0] period_value,
  input wire logic period_match,
  input wire logic run_state
);
  // ----------------------------------------------------------------
  // Mode shadow and properties
  // ----------------------------------------------------------------
  logic [4:0] mode_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Follows the mode field through register writes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 5'h00;
    end else if (bus_req.wr && bus_req.addr == HLTM_OFS_MODE) begin
      mode_r <= bus_req.wdata[4:0];
    end
  end
  // Run has stood long enough to pass its delay stages, with no write now.
  sequence s_run_on;
    run_state && $past(run_state) && $past(run_state, 2) && !bus_req.wr;
  endsequence
  // Counting at the period value, which must wrap on the next clock.
  sequence s_at_top;
    s_run_on ##0 count_value == period_value;
  endsequence
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_swgate_inc: assert property ((mode_r == HLTM_M_SWGATE && count_value != period_value)
    ##0 s_run_on |=> count_value == $past(count_value) + 8'h01)
    else $error("count did not advance by one");
  a_swgate_hold: assert property (mode_r == HLTM_M_SWGATE && !bus_req.wr && !run_state
    && !$past(run_state) && !$past(run_state, 2) && count_value != period_value
    |=> $stable(count_value)) else $error("count moved with run clear");
  a_wrap_zero: assert property (mode_r == HLTM_M_SWGATE ##0 s_at_top
    |=> count_value == 8'h00) else $error("count did not wrap");
  a_match_pulse: assert property (period_match |-> count_value == 8'h00
    && $past(count_value) == $past(period_value)) else $error("stray match pulse");
  a_gate_hold: assert property ((ext_reset_signal && mode_r == HLTM_M_GATE_HI)[*5]
    ##0 s_run_on ##0 count_value != period_value |=> $stable(count_value))
    else $error("gated count moved");
  a_level_reset: assert property ((ext_reset_signal && mode_r == HLTM_M_LLIM_HI)[*5]
    ##0 s_run_on |=> count_value == 8'h00) else $error("count not held at reset level");
  a_oneshot_end: assert property (mode_r == HLTM_M_OS_SW ##0 s_at_top
    |=> !run_state && count_value == 8'h00) else $error("one-shot did not end");
  a_mono_stop: assert property (mode_r inside {5'h11, 5'h12, 5'h13} ##0 s_at_top
    |=> run_state && count_value == 8'h00) else $error("monostable end wrong");
endmodule
bind hltm_timer hltm_timer_chk hltm_timer_chk_inst (.clk(clk), .rst_n(rst_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .ext_reset_signal(ext_reset_signal),
  .count_value(count_value), .period_value(period_value), .period_match(period_match),
  .run_state(run_state));

// ---- dv/tb.sv ----
// Self-checking bench for the hardware limit timer.
`timescale 1ns/100ps
module tb;
  import hltm_pkg::*;
  // ----------------------------------------------------------------
  // Signals, tasks and tests
  // ----------------------------------------------------------------
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic lvl = 1'h0;
  hltm_req_type bus_req = '0;
  logic [7:0] bus_rdata;
  logic [7:0] count_value;
  logic [7:0] period_value;
  logic [7:0] v;
  logic [9:0] e;
  logic period_match;
  logic run_state;
  logic ext_reset_signal;
  int err_total = 0;
  int checked = 0;
  int m;
  // Start table: mode, idle level, start level, needs start, run after end, reruns.
  localparam logic [9:0] OS_TAB [13] = '{10'h101, 10'h12c, 10'h154, 10'h16c, 10'h18c,
    10'h1b4, 10'h1cc, 10'h1f4, 10'h22e, 10'h256, 10'h26e, 10'h2cd, 10'h2f5};
  hltm_timer hltm_timer_inst (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .ext_reset_signal(ext_reset_signal), .count_value(count_value),
    .period_value(period_value), .period_match(period_match), .run_state(run_state));
  hltm_ers_model hltm_ers_model_inst (.clk(clk), .lvl(lvl),
    .ext_reset_signal(ext_reset_signal));
  // Free-running 250 MHz clock.
  initial forever #2 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{a, d, 1'h1, 1'h0};
    @(posedge clk) bus_req.wr <= 1'h0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk) bus_req <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge clk) bus_req.rd <= 1'h0;
    #1 v = bus_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setup(input logic [4:0] md, input logic [7:0] per, input logic lv);
    wr(HLTM_OFS_CTRL, 8'h00);
    lvl <= lv;
    wr(HLTM_OFS_MODE, {3'h0, md});
    wr(HLTM_OFS_PERIOD, per);
    wr(HLTM_OFS_COUNT, 8'h00);
    cyc(4);
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    cyc(1);
    chk("period port", period_value, 8'hff);
    for (m = 0; m < 4; m++) begin
      rd(m[1:0]);
      chk("reset reg", v, m == 1 ? 8'hff : 8'h00);
    end
    setup(HLTM_M_SWGATE, 8'h05, 1'h0);
    wr(HLTM_OFS_CTRL, 8'h80);
    cyc(3);
    for (m = 1; m <= 5; m++) begin
      chk("sw count", count_value, m[7:0]);
      cyc(1);
    end
    chk("wrap", count_value, 8'h00);
    chk("match", {7'h0, period_match}, 8'h01);
    wr(HLTM_OFS_PERIOD, 8'h20);
    wr(HLTM_OFS_CTRL, 8'h00);
    cyc(6);
    rd(HLTM_OFS_COUNT);
    cyc(6);
    chk("hold", count_value, v);
    for (m = 1; m <= 2; m++) begin
      setup(m[4:0], 8'hff, m == 1);
      wr(HLTM_OFS_CTRL, 8'h80);
      cyc(8);
      chk("gate stop", count_value, 8'h00);
      lvl <= m != 1;
      cyc(8);
      chk("gate run", {7'h0, count_value > 8'h02}, 8'h01);
    end
    for (m = 3; m <= 5; m++) begin
      setup(m[4:0], 8'hff, 1'h0);
      wr(HLTM_OFS_CTRL, 8'h80);
      cyc(12);
      lvl <= 1'h1;
      cyc(6);
      chk("rise limit", {7'h0, count_value < 8'h06}, {7'h0, m != 5});
      cyc(8);
      lvl <= 1'h0;
      cyc(6);
      chk("fall limit", {7'h0, count_value < 8'h06}, {7'h0, m != 4});
    end
    for (m = 6; m <= 7; m++) begin
      setup(m[4:0], 8'hff, m == 6);
      wr(HLTM_OFS_CTRL, 8'h80);
      cyc(10);
      lvl <= m == 7;
      cyc(8);
      chk("level reset", count_value, 8'h00);
      lvl <= m == 6;
      cyc(8);
      chk("level run", {7'h0, count_value > 8'h02}, 8'h01);
      wr(HLTM_OFS_CTRL, 8'h00);
      lvl <= m == 7;
      wr(HLTM_OFS_COUNT, 8'h09);
      cyc(8);
      chk("level off", count_value, 8'h09);
    end
    for (m = 0; m < 13; m++) begin
      e = OS_TAB[m];
      setup(e[9:5], 8'h10, e[4]);
      wr(HLTM_OFS_CTRL, 8'h80);
      cyc(6);
      if (e[2]) begin
        chk("no start", count_value, 8'h00);
        lvl <= e[3];
      end
      for (int n = 0; n < 40 && count_value !== 8'h10; n++) cyc(1);
      chk("top", count_value, 8'h10);
      cyc(3);
      chk("end count", count_value, 8'h00);
      chk("end run", {7'h0, run_state}, {7'h0, e[1]});
      wr(HLTM_OFS_CTRL, 8'h80);
      cyc(8);
      chk("rerun", {7'h0, count_value != 8'h00}, {7'h0, e[0]});
    end
    print_verdict();
  end
endmodule
